// ==== rtl/cbs_seq.v ====
// Bus cycle sequencer for indexed and extended addressing instructions
`timescale 1ns/1ps
`include "cbs_seq_map.vh"

module cbs_seq
(
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // Core request side
    input  wire        start,
    input  wire [3:0]  instr_class,
    input  wire [15:0] opcode_addr,
    input  wire [15:0] index_reg,
    input  wire [15:0] stack_ptr,
    input  wire [15:0] store_data,
    input  wire [7:0]  alu_result,
    // Core answer side
    output wire        busy,
    output reg         done_q,
    output reg  [7:0]  operand_q,
    output reg  [7:0]  next_opcode_q,
    // System bus
    output reg  [15:0] bus_addr_q,
    output reg         bus_rw_q,
    input  wire [7:0]  bus_d_in,
    output reg  [7:0]  bus_d_out_q,
    output reg         bus_d_oe_n_q
);

    // ------------------------------------------------------------
    // Local constants
    // ------------------------------------------------------------
    localparam [1:0] PH_LAST = `CBS_BUS_PH_LAST;
    localparam       S_IDLE  = 1'b0;
    localparam       S_RUN   = 1'b1;

    // ------------------------------------------------------------
    // Step table: one entry per bus cycle of each class
    // ------------------------------------------------------------
    function [10:0] cbs_step;
        input [3:0] cls;
        input [2:0] stp;
        begin
            case ({cls, stp})
                // Indexed 8-bit read
                {`CBS_IDX_RD8, 3'h0}: cbs_step = {2'b01, `CBS_A_PC1, `CBS_D_NONE, `CBS_C_ALO};
                {`CBS_IDX_RD8, 3'h1}: cbs_step = {2'b01, `CBS_A_DUMMY, `CBS_D_NONE, `CBS_C_NONE};
                {`CBS_IDX_RD8, 3'h2}: cbs_step = {2'b01, `CBS_A_EA, `CBS_D_NONE, `CBS_C_OPLO};
                {`CBS_IDX_RD8, 3'h3}: cbs_step = {2'b11, `CBS_A_PC2, `CBS_D_NONE, `CBS_C_OPC};
                // Indexed read-modify-write [RL1]
                {`CBS_IDX_RMW, 3'h0}: cbs_step = {2'b01, `CBS_A_PC1, `CBS_D_NONE, `CBS_C_ALO};
                {`CBS_IDX_RMW, 3'h1}: cbs_step = {2'b01, `CBS_A_DUMMY, `CBS_D_NONE, `CBS_C_NONE};
                {`CBS_IDX_RMW, 3'h2}: cbs_step = {2'b01, `CBS_A_EA, `CBS_D_NONE, `CBS_C_OPLO};
                {`CBS_IDX_RMW, 3'h3}: cbs_step = {2'b01, `CBS_A_DUMMY, `CBS_D_NONE, `CBS_C_NONE};
                {`CBS_IDX_RMW, 3'h4}: cbs_step = {2'b00, `CBS_A_EA, `CBS_D_ALU, `CBS_C_NONE};
                {`CBS_IDX_RMW, 3'h5}: cbs_step = {2'b11, `CBS_A_PC2, `CBS_D_NONE, `CBS_C_OPC};
                // Indexed subroutine call [RL2]
                {`CBS_IDX_JSR, 3'h0}: cbs_step = {2'b01, `CBS_A_PC1, `CBS_D_NONE, `CBS_C_ALO};
                {`CBS_IDX_JSR, 3'h1}: cbs_step = {2'b01, `CBS_A_DUMMY, `CBS_D_NONE, `CBS_C_NONE};
                {`CBS_IDX_JSR, 3'h2}: cbs_step = {2'b00, `CBS_A_SP, `CBS_D_RETLO, `CBS_C_NONE};
                {`CBS_IDX_JSR, 3'h3}: cbs_step = {2'b00, `CBS_A_SPM1, `CBS_D_RETHI, `CBS_C_NONE};
                {`CBS_IDX_JSR, 3'h4}: cbs_step = {2'b11, `CBS_A_EA, `CBS_D_NONE, `CBS_C_OPC};
                // Indexed clear
                {`CBS_IDX_CLR, 3'h0}: cbs_step = {2'b01, `CBS_A_PC1, `CBS_D_NONE, `CBS_C_ALO};
                {`CBS_IDX_CLR, 3'h1}: cbs_step = {2'b01, `CBS_A_DUMMY, `CBS_D_NONE, `CBS_C_NONE};
                {`CBS_IDX_CLR, 3'h2}: cbs_step = {2'b01, `CBS_A_EA, `CBS_D_NONE, `CBS_C_OPLO};
                {`CBS_IDX_CLR, 3'h3}: cbs_step = {2'b00, `CBS_A_EA, `CBS_D_ZERO, `CBS_C_NONE};
                {`CBS_IDX_CLR, 3'h4}: cbs_step = {2'b11, `CBS_A_PC2, `CBS_D_NONE, `CBS_C_OPC};
                // Extended 8-bit read [RL4]
                {`CBS_EXT_RD8, 3'h0}: cbs_step = {2'b01, `CBS_A_PC1, `CBS_D_NONE, `CBS_C_AHI};
                {`CBS_EXT_RD8, 3'h1}: cbs_step = {2'b01, `CBS_A_PC2, `CBS_D_NONE, `CBS_C_ALO};
                {`CBS_EXT_RD8, 3'h2}: cbs_step = {2'b01, `CBS_A_EA, `CBS_D_NONE, `CBS_C_OPLO};
                {`CBS_EXT_RD8, 3'h3}: cbs_step = {2'b11, `CBS_A_PC3, `CBS_D_NONE, `CBS_C_OPC};
                // Extended 16-bit store [RL3]
                {`CBS_EXT_ST16, 3'h0}: cbs_step = {2'b01, `CBS_A_PC1, `CBS_D_NONE, `CBS_C_AHI};
                {`CBS_EXT_ST16, 3'h1}: cbs_step = {2'b01, `CBS_A_PC2, `CBS_D_NONE, `CBS_C_ALO};
                {`CBS_EXT_ST16, 3'h2}: cbs_step = {2'b00, `CBS_A_EA, `CBS_D_HI, `CBS_C_NONE};
                {`CBS_EXT_ST16, 3'h3}: cbs_step = {2'b00, `CBS_A_EA1, `CBS_D_LO, `CBS_C_NONE};
                {`CBS_EXT_ST16, 3'h4}: cbs_step = {2'b11, `CBS_A_PC3, `CBS_D_NONE, `CBS_C_OPC};
                // Extended clear [RL5]
                {`CBS_EXT_CLR, 3'h0}: cbs_step = {2'b01, `CBS_A_PC1, `CBS_D_NONE, `CBS_C_AHI};
                {`CBS_EXT_CLR, 3'h1}: cbs_step = {2'b01, `CBS_A_PC2, `CBS_D_NONE, `CBS_C_ALO};
                {`CBS_EXT_CLR, 3'h2}: cbs_step = {2'b01, `CBS_A_EA, `CBS_D_NONE, `CBS_C_OPLO};
                {`CBS_EXT_CLR, 3'h3}: cbs_step = {2'b00, `CBS_A_EA, `CBS_D_ZERO, `CBS_C_NONE};
                {`CBS_EXT_CLR, 3'h4}: cbs_step = {2'b11, `CBS_A_PC3, `CBS_D_NONE, `CBS_C_OPC};
                // Extended read-modify-write
                {`CBS_EXT_RMW, 3'h0}: cbs_step = {2'b01, `CBS_A_PC1, `CBS_D_NONE, `CBS_C_AHI};
                {`CBS_EXT_RMW, 3'h1}: cbs_step = {2'b01, `CBS_A_PC2, `CBS_D_NONE, `CBS_C_ALO};
                {`CBS_EXT_RMW, 3'h2}: cbs_step = {2'b01, `CBS_A_EA, `CBS_D_NONE, `CBS_C_OPLO};
                {`CBS_EXT_RMW, 3'h3}: cbs_step = {2'b01, `CBS_A_DUMMY, `CBS_D_NONE, `CBS_C_NONE};
                {`CBS_EXT_RMW, 3'h4}: cbs_step = {2'b00, `CBS_A_EA, `CBS_D_ALU, `CBS_C_NONE};
                {`CBS_EXT_RMW, 3'h5}: cbs_step = {2'b11, `CBS_A_PC3, `CBS_D_NONE, `CBS_C_OPC};
                // Extended subroutine call
                {`CBS_EXT_JSR, 3'h0}: cbs_step = {2'b01, `CBS_A_PC1, `CBS_D_NONE, `CBS_C_AHI};
                {`CBS_EXT_JSR, 3'h1}: cbs_step = {2'b01, `CBS_A_PC2, `CBS_D_NONE, `CBS_C_ALO};
                {`CBS_EXT_JSR, 3'h2}: cbs_step = {2'b01, `CBS_A_DUMMY, `CBS_D_NONE, `CBS_C_NONE};
                {`CBS_EXT_JSR, 3'h3}: cbs_step = {2'b00, `CBS_A_SP, `CBS_D_RETLO, `CBS_C_NONE};
                {`CBS_EXT_JSR, 3'h4}: cbs_step = {2'b00, `CBS_A_SPM1, `CBS_D_RETHI, `CBS_C_NONE};
                {`CBS_EXT_JSR, 3'h5}: cbs_step = {2'b11, `CBS_A_EA, `CBS_D_NONE, `CBS_C_OPC};
                // Unknown class ends at once with a dummy cycle
                default: cbs_step = {2'b11, `CBS_A_DUMMY, `CBS_D_NONE, `CBS_C_NONE};
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg         state_q;
    reg  [1:0]  phase_q;
    reg  [2:0]  step_q;
    reg  [3:0]  class_q;
    reg  [15:0] pc_q;
    reg  [15:0] idx_q;
    reg  [15:0] sp_q;
    reg  [15:0] wdata_q;
    reg  [7:0]  ahi_q;
    reg  [7:0]  alo_q;
    reg  [7:0]  din_meta_q;
    reg  [7:0]  din_sync_q;

    // ------------------------------------------------------------
    // Next-cycle decode
    // ------------------------------------------------------------
    reg         launch;
    reg  [3:0]  cls_n;
    reg  [2:0]  stp_n;
    reg  [15:0] pc_n;
    reg  [15:0] idx_n;
    reg  [15:0] sp_n;
    reg  [15:0] wd_n;
    reg  [7:0]  ahi_d;
    reg  [7:0]  alo_d;
    reg  [10:0] ent_cur;
    reg  [10:0] ent_n;
    reg  [15:0] ea_n;
    reg  [15:0] ret_n;
    reg  [15:0] addr_d;
    reg  [7:0]  dout_d;
    wire        cyc_end;

    assign busy    = (state_q == S_RUN);
    assign cyc_end = busy && (phase_q == PH_LAST);

    // Capture of the current cycle and the entry of the following one
    always @*
    begin
        ent_cur = cbs_step(class_q, step_q);
        ahi_d   = ahi_q;
        alo_d   = alo_q;
        if (cyc_end && ent_cur[`CBS_E_CS_HI:`CBS_E_CS_LO] == `CBS_C_AHI)
            ahi_d = din_sync_q;
        if (cyc_end && ent_cur[`CBS_E_CS_HI:`CBS_E_CS_LO] == `CBS_C_ALO)
            alo_d = din_sync_q;
        launch = 1'b0;
        cls_n  = class_q;
        stp_n  = step_q + 3'h1;
        pc_n   = pc_q;
        idx_n  = idx_q;
        sp_n   = sp_q;
        wd_n   = wdata_q;
        if (!busy && start)
        begin
            launch = 1'b1;
            cls_n  = instr_class;
            stp_n  = 3'h0;
            pc_n   = opcode_addr;
            idx_n  = index_reg;
            sp_n   = stack_ptr;
            wd_n   = store_data;
        end
        else if (cyc_end && !ent_cur[`CBS_E_LAST])
            launch = 1'b1;
        ent_n = cbs_step(cls_n, stp_n);
    end

    // Effective and return addresses
    always @*
    begin
        if (cls_n >= `CBS_EXT_RD8)
        begin
            ea_n  = {ahi_d, alo_d};
            ret_n = pc_n + 16'h0003;
        end
        else
        begin
            ea_n  = idx_n + {8'h00, alo_d};                    // [RL6]
            ret_n = pc_n + 16'h0002;
        end
    end

    // Address and write data for the following cycle
    always @*
    begin
        case (ent_n[`CBS_E_AS_HI:`CBS_E_AS_LO])
            `CBS_A_PC1:   addr_d = pc_n + 16'h0001;
            `CBS_A_PC2:   addr_d = pc_n + 16'h0002;
            `CBS_A_PC3:   addr_d = pc_n + 16'h0003;
            `CBS_A_EA:    addr_d = ea_n;
            `CBS_A_EA1:   addr_d = ea_n + 16'h0001;                // [RL3]
            `CBS_A_SP:    addr_d = sp_n;                           // [RL2]
            `CBS_A_SPM1:  addr_d = sp_n - 16'h0001;                // [RL2]
            default:      addr_d = `CBS_DUMMY_ADDR;                // [RL1]
        endcase
        case (ent_n[`CBS_E_DS_HI:`CBS_E_DS_LO])
            `CBS_D_HI:    dout_d = wd_n[15:8];                     // [RL3]
            `CBS_D_LO:    dout_d = wd_n[7:0];                      // [RL3]
            `CBS_D_ZERO:  dout_d = `CBS_CLEAR_DATA;                // [RL5]
            `CBS_D_ALU:   dout_d = alu_result;                     // [RL1]
            `CBS_D_RETLO: dout_d = ret_n[7:0];                     // [RL2]
            `CBS_D_RETHI: dout_d = ret_n[15:8];                    // [RL2]
            default:      dout_d = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Data bus synchroniser
    // ------------------------------------------------------------
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            din_meta_q <= 8'h00;
            din_sync_q <= 8'h00;
        end
        else
        begin
            din_meta_q <= bus_d_in;
            din_sync_q <= din_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Sequencer and bus drivers
    // ------------------------------------------------------------
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q       <= S_IDLE;
            phase_q       <= 2'h0;
            step_q        <= 3'h0;
            class_q       <= 4'h0;
            pc_q          <= 16'h0000;
            idx_q         <= 16'h0000;
            sp_q          <= 16'h0000;
            wdata_q       <= 16'h0000;
            ahi_q         <= 8'h00;
            alo_q         <= 8'h00;
            operand_q     <= 8'h00;
            next_opcode_q <= 8'h00;
            done_q        <= 1'b0;
            bus_addr_q    <= `CBS_DUMMY_ADDR;
            bus_rw_q      <= 1'b1;
            bus_d_out_q   <= 8'h00;
            bus_d_oe_n_q  <= 1'b1;
        end
        else
        begin
            ahi_q  <= ahi_d;
            alo_q  <= alo_d;
            done_q <= 1'b0;
            if (busy)
                phase_q <= phase_q + 2'h1;
            // Read captures at the end of the cycle
            if (cyc_end && ent_cur[`CBS_E_CS_HI:`CBS_E_CS_LO] == `CBS_C_OPLO)
                operand_q <= din_sync_q;                           // [RL4]
            if (cyc_end && ent_cur[`CBS_E_CS_HI:`CBS_E_CS_LO] == `CBS_C_OPC)
                next_opcode_q <= din_sync_q;
            if (launch)
            begin
                state_q      <= S_RUN;
                phase_q      <= 2'h0;
                step_q       <= stp_n;
                class_q      <= cls_n;
                pc_q         <= pc_n;
                idx_q        <= idx_n;
                sp_q         <= sp_n;
                wdata_q      <= wd_n;
                bus_addr_q   <= addr_d;
                bus_rw_q     <= ent_n[`CBS_E_RW];                  // [RL5]
                bus_d_out_q  <= dout_d;
                bus_d_oe_n_q <= ent_n[`CBS_E_RW];
            end
            else if (cyc_end)
            begin
                // Last cycle done: park the bus on a dummy read
                state_q      <= S_IDLE;
                done_q       <= 1'b1;
                bus_addr_q   <= `CBS_DUMMY_ADDR;
                bus_rw_q     <= 1'b1;
                bus_d_oe_n_q <= 1'b1;
            end
        end
    end

endmodule

// ==== rtl/cbs_seq_map.vh ====
// Constants for the indexed and extended bus cycle sequencer
//
// Notes on behaviour
// RL1 - Indexed read-modify-write: six cycles, two dummy reads
// RL2 - Indexed call: offset, dummy, push return, jump
// RL3 - Extended 16-bit store: high then low byte
// RL4 - Extended 8-bit read: four cycles total
// RL5 - Extended clear: read, then write 00
// RL6 - Indexed address is index plus unsigned offset
`ifndef CBS_SEQ_MAP_VH
`define CBS_SEQ_MAP_VH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CBS_MCLK_PERIOD_NS  25
`define CBS_BUS_CYCLE_NS    100
`define CBS_BUS_CYCLE_CLKS  (`CBS_BUS_CYCLE_NS / `CBS_MCLK_PERIOD_NS)
`define CBS_BUS_PH_LAST     2'h3

// ------------------------------------------------------------
// Bus constants
// ------------------------------------------------------------
`define CBS_DUMMY_ADDR      16'hFFFF
`define CBS_CLEAR_DATA      8'h00

// ------------------------------------------------------------
// Instruction classes
// ------------------------------------------------------------
`define CBS_IDX_RD8         4'h0
`define CBS_IDX_RMW         4'h1
`define CBS_IDX_JSR         4'h2
`define CBS_IDX_CLR         4'h3
`define CBS_EXT_RD8         4'h4
`define CBS_EXT_ST16        4'h5
`define CBS_EXT_CLR         4'h6
`define CBS_EXT_RMW         4'h7
`define CBS_EXT_JSR         4'h8

// ------------------------------------------------------------
// Address selects
// ------------------------------------------------------------
`define CBS_A_PC1           3'h0
`define CBS_A_PC2           3'h1
`define CBS_A_PC3           3'h2
`define CBS_A_DUMMY         3'h3
`define CBS_A_EA            3'h4
`define CBS_A_EA1           3'h5
`define CBS_A_SP            3'h6
`define CBS_A_SPM1          3'h7

// ------------------------------------------------------------
// Write data selects
// ------------------------------------------------------------
`define CBS_D_NONE          3'h0
`define CBS_D_HI            3'h1
`define CBS_D_LO            3'h2
`define CBS_D_ZERO          3'h3
`define CBS_D_ALU           3'h4
`define CBS_D_RETLO         3'h5
`define CBS_D_RETHI         3'h6

// ------------------------------------------------------------
// Read capture selects
// ------------------------------------------------------------
`define CBS_C_NONE          3'h0
`define CBS_C_AHI           3'h1
`define CBS_C_ALO           3'h2
`define CBS_C_OPLO          3'h3
`define CBS_C_OPC           3'h4

// ------------------------------------------------------------
// Step entry layout {last, rw, asel, dsel, csel}
// ------------------------------------------------------------
`define CBS_E_LAST          10
`define CBS_E_RW            9
`define CBS_E_AS_HI         8
`define CBS_E_AS_LO         6
`define CBS_E_DS_HI         5
`define CBS_E_DS_LO         3
`define CBS_E_CS_HI         2
`define CBS_E_CS_LO         0

`endif

// ==== sim/cbs_mem_model.sv ====
// Behavioural external memory on the system bus
`timescale 1ns/1ps

module cbs_mem_model
(
    // Clock
    input  wire        mclk,
    // System bus from the sequencer
    input  wire [15:0] bus_addr,
    input  wire        bus_rw,
    input  wire [7:0]  bus_d_out,
    input  wire        bus_d_oe_n,
    // Resolved data wire
    output wire [7:0]  bus_d_in
);
    reg  [7:0]  mem [0:65535];
    reg  [16:0] prev_q;
    integer     a;

    // Pattern fill: low address bits under a fixed mask
    initial
    begin
        prev_q = 17'h00000;
        for (a = 0; a < 65536; a = a + 1)
            mem[a] = a[7:0] ^ 8'hA5;
    end

    // Store written bytes, remember last address and direction
    always @(posedge mclk)
    begin
        prev_q <= {bus_addr, bus_rw};
        if (!bus_d_oe_n)
            mem[bus_addr] <= bus_d_out;
    end

    // Device wins when driving; memory shows garbage for the first clock
    assign bus_d_in = !bus_d_oe_n ? bus_d_out :
                      (prev_q == {bus_addr, bus_rw}) ? mem[bus_addr] : ~mem[bus_addr];
endmodule

// ==== sim/cbs_seq_checker.sv ====
// Concurrent checks on the bus cycle sequencer ports
`timescale 1ns/1ps
`include "cbs_seq_map.vh"

module cbs_seq_checker
(
    // Clock and reset
    input wire        mclk,
    input wire        rst_n,
    // Core side
    input wire        start,
    input wire [3:0]  instr_class,
    input wire [15:0] opcode_addr,
    input wire [15:0] index_reg,
    input wire [15:0] stack_ptr,
    input wire [15:0] store_data,
    input wire [7:0]  alu_result,
    input wire        busy,
    input wire        done_q,
    input wire [7:0]  operand_q,
    input wire [7:0]  next_opcode_q,
    // System bus
    input wire [15:0] bus_addr_q,
    input wire        bus_rw_q,
    input wire [7:0]  bus_d_in,
    input wire [7:0]  bus_d_out_q,
    input wire        bus_d_oe_n_q
);
    reg  [15:0] opc_q;
    reg  [15:0] ix_q;
    reg  [15:0] sp_q;
    reg  [15:0] sd_q;
    wire        take = start && !busy;
    wire [15:0] ret  = opc_q + 16'h0002;

    // Request operands held from the taking edge
    always @(posedge mclk)
    begin
        if (take)
        begin
            opc_q <= opcode_addr;
            ix_q  <= index_reg;
            sp_q  <= stack_ptr;
            sd_q  <= store_data;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_IDX_RMW: assert property (take && instr_class == `CBS_IDX_RMW |=>
        ##4 (bus_addr_q == `CBS_DUMMY_ADDR && bus_rw_q) ##8 (bus_addr_q == `CBS_DUMMY_ADDR)
        ##4 !bus_rw_q ##4 bus_rw_q ##4 done_q) else $error("indexed rmw cycle order wrong");
    AST_IDX_JSR: assert property (take && instr_class == `CBS_IDX_JSR |=>
        ##8 (bus_addr_q == sp_q && !bus_rw_q && bus_d_out_q == ret[7:0])
        ##4 (bus_addr_q == sp_q - 16'h0001 && !bus_rw_q && bus_d_out_q == ret[15:8])
        ##8 done_q) else $error("indexed call push wrong");
    AST_EXT_ST16: assert property (take && instr_class == `CBS_EXT_ST16 |=>
        ##8 (!bus_rw_q && bus_d_out_q == sd_q[15:8])
        ##4 (!bus_rw_q && bus_addr_q == $past(bus_addr_q, 4) + 16'h0001
        && bus_d_out_q == sd_q[7:0]) ##8 done_q) else $error("16-bit store wrong");
    AST_EXT_RD8: assert property (take && instr_class == `CBS_EXT_RD8 |=>
        (bus_addr_q == opc_q + 16'h0001) ##4 (bus_addr_q == opc_q + 16'h0002)
        ##8 (bus_addr_q == opc_q + 16'h0003 && bus_rw_q) ##4 done_q)
        else $error("extended read cycles wrong");
    AST_EXT_CLR: assert property (take && instr_class == `CBS_EXT_CLR |=>
        ##8 bus_rw_q ##4 (!bus_rw_q && bus_d_out_q == `CBS_CLEAR_DATA
        && bus_addr_q == $past(bus_addr_q, 4)) ##8 done_q) else $error("clear write wrong");
    AST_IDX_EA: assert property (take && instr_class == `CBS_IDX_RMW |=>
        ##8 (bus_addr_q == ix_q + {8'h00, $past(bus_d_in, 5)}))
        else $error("indexed address wrong");
    AST_DONE_PULSE: assert property (done_q |=> !done_q) else $error("done longer than one cycle");
    AST_IDLE_PARK: assert property (!busy |-> bus_addr_q == `CBS_DUMMY_ADDR && bus_rw_q)
        else $error("idle bus not parked");
endmodule

bind cbs_seq cbs_seq_checker cbs_seq_checker_i
(
    .mclk(mclk), .rst_n(rst_n), .start(start), .instr_class(instr_class),
    .opcode_addr(opcode_addr), .index_reg(index_reg), .stack_ptr(stack_ptr),
    .store_data(store_data), .alu_result(alu_result), .busy(busy), .done_q(done_q),
    .operand_q(operand_q), .next_opcode_q(next_opcode_q), .bus_addr_q(bus_addr_q),
    .bus_rw_q(bus_rw_q), .bus_d_in(bus_d_in), .bus_d_out_q(bus_d_out_q),
    .bus_d_oe_n_q(bus_d_oe_n_q)
);

// ==== sim/tb_top.sv ====
// Self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
`include "cbs_seq_map.vh"
`define CHK(nm, ex, got) begin tests_run = tests_run + 1; if ((got) !== (ex)) begin failures = failures + 1; $display("BAD %s exp %h got %h", nm, ex, got); end end

module tb_top;
    reg         mclk = 1'b0;
    reg         rst_n = 1'b0;
    reg         start = 1'b0;
    reg  [3:0]  instr_class = 4'h0;
    reg  [15:0] opcode_addr = 16'h0000;
    reg  [15:0] index_reg = 16'h0000;
    reg  [15:0] stack_ptr = 16'h0000;
    reg  [15:0] store_data = 16'h0000;
    reg  [7:0]  alu_result = 8'h00;
    wire        busy;
    wire        done_q;
    wire [7:0]  operand_q;
    wire [7:0]  next_opcode_q;
    wire [15:0] bus_addr_q;
    wire        bus_rw_q;
    wire [7:0]  bus_d_in;
    wire [7:0]  bus_d_out_q;
    wire        bus_d_oe_n_q;
    integer     failures = 0;
    integer     tests_run = 0;
    reg  [15:0] exp_a [0:5];
    reg         exp_w [0:5];
    reg  [7:0]  exp_d [0:5];
    reg  [15:0] ea;
    reg  [7:0]  old;

    always #12.5 mclk = ~mclk;

    cbs_seq cbs_seq_i (.mclk(mclk), .rst_n(rst_n), .start(start), .instr_class(instr_class),
        .opcode_addr(opcode_addr), .index_reg(index_reg), .stack_ptr(stack_ptr),
        .store_data(store_data), .alu_result(alu_result), .busy(busy), .done_q(done_q),
        .operand_q(operand_q), .next_opcode_q(next_opcode_q), .bus_addr_q(bus_addr_q),
        .bus_rw_q(bus_rw_q), .bus_d_in(bus_d_in), .bus_d_out_q(bus_d_out_q),
        .bus_d_oe_n_q(bus_d_oe_n_q));
    cbs_mem_model cbs_mem_model_i (.mclk(mclk), .bus_addr(bus_addr_q), .bus_rw(bus_rw_q),
        .bus_d_out(bus_d_out_q), .bus_d_oe_n(bus_d_oe_n_q), .bus_d_in(bus_d_in));

    // Expected bus cycle entry
    task set(input integer k, input [15:0] a, input w, input [7:0] d);
        begin
            exp_a[k] = a;
            exp_w[k] = w;
            exp_d[k] = d;
        end
    endtask

    // One instruction; start held over a busy edge, where it must be ignored
    task run(input integer n);
        integer i;
        begin
            start = 1'b1;
            for (i = 0; i < 4 * n; i = i + 1)
            begin
                @(negedge mclk);
                if (i == 1)
                    start = 1'b0;
                if (i % 4 == 0)
                begin
                    `CHK("addr", exp_a[i / 4], bus_addr_q)
                    `CHK("rw", exp_w[i / 4], bus_rw_q)
                    `CHK("oe_n", exp_w[i / 4], bus_d_oe_n_q)
                    `CHK("busy", 1'b1, busy)
                    if (!exp_w[i / 4])
                        `CHK("wdata", exp_d[i / 4], bus_d_out_q)
                end
            end
            @(negedge mclk);
            `CHK("done", 1'b1, done_q)
            `CHK("busy end", 1'b0, busy)
        end
    endtask

    // Indexed read-modify-write with carry into the high byte
    task t_idx_rmw;
        begin
            instr_class = `CBS_IDX_RMW;
            opcode_addr = 16'h0100;
            index_reg = 16'h20FF;
            alu_result = 8'h3C;
            ea = index_reg + {8'h00, cbs_mem_model_i.mem[16'h0101]};
            old = cbs_mem_model_i.mem[ea];
            set(0, 16'h0101, 1'b1, 8'h00);
            set(1, 16'hFFFF, 1'b1, 8'h00);
            set(2, ea, 1'b1, 8'h00);
            set(3, 16'hFFFF, 1'b1, 8'h00);
            set(4, ea, 1'b0, 8'h3C);
            set(5, 16'h0102, 1'b1, 8'h00);
            run(6);
            `CHK("rmw operand", old, operand_q)
            `CHK("rmw next", cbs_mem_model_i.mem[16'h0102], next_opcode_q)
        end
    endtask

    // Indexed call pushes return address then jumps
    task t_idx_jsr;
        begin
            instr_class = `CBS_IDX_JSR;
            opcode_addr = 16'h12F0;
            index_reg = 16'h0300;
            stack_ptr = 16'h01FF;
            ea = index_reg + {8'h00, cbs_mem_model_i.mem[16'h12F1]};
            set(0, 16'h12F1, 1'b1, 8'h00);
            set(1, 16'hFFFF, 1'b1, 8'h00);
            set(2, 16'h01FF, 1'b0, 8'hF2);
            set(3, 16'h01FE, 1'b0, 8'h12);
            set(4, ea, 1'b1, 8'h00);
            run(5);
            `CHK("jsr target", cbs_mem_model_i.mem[ea], next_opcode_q)
        end
    endtask

    // Extended 16-bit store, 8-bit read back, then clear of the same byte
    task t_ext(input [3:0] cls, input integer n, input [15:0] opc);
        begin
            instr_class = cls;
            opcode_addr = opc;
            store_data = 16'hBEEF;
            ea = {cbs_mem_model_i.mem[opc + 16'h0001], cbs_mem_model_i.mem[opc + 16'h0002]};
            old = cbs_mem_model_i.mem[ea];
            set(0, opc + 16'h0001, 1'b1, 8'h00);
            set(1, opc + 16'h0002, 1'b1, 8'h00);
            set(2, ea, cls != `CBS_EXT_ST16, 8'hBE);
            if (n > 4)
                set(n - 2, (cls == `CBS_EXT_ST16) ? ea + 16'h0001 : ea, 1'b0,
                (cls == `CBS_EXT_ST16) ? 8'hEF : 8'h00);
            set(n - 1, opc + 16'h0003, 1'b1, 8'h00);
            run(n);
            if (cls != `CBS_EXT_ST16)
                `CHK("ext operand", old, operand_q)
            `CHK("ext next", cbs_mem_model_i.mem[opc + 16'h0003], next_opcode_q)
        end
    endtask

    // Indexed clear: read, write 00, then next opcode
    task t_idx_clr;
        begin
            instr_class = `CBS_IDX_CLR;
            opcode_addr = 16'h0700;
            index_reg = 16'h0800;
            ea = index_reg + {8'h00, cbs_mem_model_i.mem[16'h0701]};
            old = cbs_mem_model_i.mem[ea];
            set(0, 16'h0701, 1'b1, 8'h00);
            set(1, 16'hFFFF, 1'b1, 8'h00);
            set(2, ea, 1'b1, 8'h00);
            set(3, ea, 1'b0, 8'h00);
            set(4, 16'h0702, 1'b1, 8'h00);
            run(5);
            `CHK("idx clr operand", old, operand_q)
            `CHK("idx clr mem", 8'h00, cbs_mem_model_i.mem[ea])
        end
    endtask

    // Verdict and end of run
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", tests_run, failures);
            if (failures == 0 && tests_run > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    // Main sequence
    initial
    begin
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        `CHK("reset addr", 16'hFFFF, bus_addr_q)
        `CHK("reset oe_n", 1'b1, bus_d_oe_n_q)
        `CHK("reset busy", 1'b0, busy)
        t_idx_rmw;
        t_idx_jsr;
        t_ext(`CBS_EXT_ST16, 5, 16'h0400);
        t_ext(`CBS_EXT_RD8, 4, 16'h0500);
        t_ext(`CBS_EXT_CLR, 5, 16'h0600);
        `CHK("clear mem", 8'h00, cbs_mem_model_i.mem[ea])
        t_idx_clr;
        print_verdict;
    end
endmodule
